// File: src/lnka_info_xfer.sv
// information transfer engine: numbered sends, window limits and receive acknowledgment
`timescale 1ns/1ns
`default_nettype none
module lnka_info_xfer #(
    parameter int SW = lnka_pkg::SEQ_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic txPending,
    output logic iStart,
    output logic [SW-1:0] iNs,
    output logic [SW-1:0] iNr,
    input wire logic iDone,
    output logic ackTimerStart,
    input wire logic ackTimerRunning,
    input wire logic localBusy,
    input wire logic remoteBusy,
    input wire logic frmrCond,
    input wire logic timerRecovery,
    input wire logic rxValid,
    input wire logic rxIsI,
    input wire logic rxIsS,
    input wire logic rxCmd,
    input wire logic rxPoll,
    input wire logic [SW-1:0] rxNs,
    input wire logic [SW-1:0] rxNr,
    output logic rxAccept,
    output logic sReq,
    input wire logic sAck,
    output logic sCmd,
    output logic sPf,
    output logic sRnr,
    output logic [SW-1:0] sNr,
    output logic sAppendOk,
    input wire logic concatOpp,
    output logic concatS
);
    function automatic logic [SW-1:0] modDiff(input logic [SW-1:0] a, input logic [SW-1:0] b);
        modDiff = a - b;
    endfunction

    lnka_pkg::lnka_state_t state_reg, state_next;
    logic [SW-1:0] vs_reg, vs_next, vr_reg, vr_next, nrLast_reg, nrLast_next;
    logic [SW-1:0] unack_reg, unack_next;
    logic [SW-1:0] k_reg, k_next, k2_reg, k2_next, k3_reg, k3_next;
    logic [lnka_pkg::RDT_W-1:0] rdt_reg, rdt_next;
    logic pollRsp_reg, pollRsp_next, k2Cmd_reg, k2Cmd_next;
    logic ackPend_reg, ackPend_next, expPend_reg, expPend_next;
    logic iStart_reg, iStart_next, ackStart_reg, ackStart_next;
    logic [SW-1:0] iNs_reg, iNs_next, iNr_reg, iNr_next;
    logic rxAcc_reg, rxAcc_next, concat_reg, concat_next;
    logic [31:0] rdata_reg, rdata_next;
    logic windowFull, iBlock, canSend, accept, rdtStart, rdtStop, rdtRun, rdtExp;
    logic [SW-1:0] unackInc;

    lnka_rdt_timer lnka_rdt_timer_inst (
        .clk(clk),
        .srst(srst),
        .start(rdtStart),
        .stop(rdtStop),
        .loadVal(rdt_reg),
        .running(rdtRun),
        .expired(rdtExp)
    );

    always_comb begin
        windowFull = (vs_reg == nrLast_reg + k_reg);
        iBlock = windowFull | frmrCond | timerRecovery | remoteBusy;
        canSend = txPending && !iBlock;
        accept = rxValid && rxIsI && !localBusy && (rxNs == vr_reg);
        unackInc = unack_reg + SW'(1);
        state_next = state_reg;
        vs_next = vs_reg;
        vr_next = vr_reg;
        nrLast_next = nrLast_reg;
        unack_next = unack_reg;
        pollRsp_next = pollRsp_reg;
        k2Cmd_next = k2Cmd_reg;
        ackPend_next = ackPend_reg;
        expPend_next = expPend_reg;
        iStart_next = 1'b0;
        ackStart_next = 1'b0;
        iNs_next = iNs_reg;
        iNr_next = iNr_reg;
        rxAcc_next = accept;
        concat_next = 1'b0;
        rdtStart = 1'b0;
        rdtStop = 1'b0;
        // acknowledgment sent as S PDU clears the pending work first, except a k2 poll behind a poll answer, so new events below win
        if (sAck && sReq) begin
            if (pollRsp_reg) begin
                pollRsp_next = 1'b0;
            end else begin
                k2Cmd_next = 1'b0;
            end
            ackPend_next = 1'b0;
            expPend_next = 1'b0;
            unack_next = '0;
        end
        case (state_reg)
            lnka_pkg::LNKA_IDLE: begin
                if (canSend) begin
                    iStart_next = 1'b1;
                    iNs_next = vs_reg;
                    iNr_next = accept ? vr_reg + SW'(1) : vr_reg;
                    ackStart_next = !ackTimerRunning;
                    rdtStop = rdtRun;
                    unack_next = '0;
                    ackPend_next = 1'b0;
                    expPend_next = 1'b0;
                    state_next = lnka_pkg::LNKA_SEND;
                end
            end
            lnka_pkg::LNKA_SEND: begin
                if (iDone) begin
                    vs_next = vs_reg + SW'(1);
                    if (modDiff(vs_reg + SW'(1), nrLast_reg) == k2_reg) begin
                        k2Cmd_next = 1'b1;
                    end
                    state_next = lnka_pkg::LNKA_IDLE;
                end
            end
            default: state_next = lnka_pkg::LNKA_IDLE;
        endcase
        if (rxValid && (rxIsI || rxIsS)) begin
            nrLast_next = rxNr;
        end
        if (rxValid && rxIsS && rxCmd && rxPoll) begin
            pollRsp_next = 1'b1;
        end
        if (accept) begin
            vr_next = vr_reg + SW'(1);
            if (!(state_reg == lnka_pkg::LNKA_IDLE && canSend)) begin
                if (rxCmd && rxPoll) begin
                    pollRsp_next = 1'b1;
                    rdtStop = 1'b1;
                end else if (unackInc >= k3_reg) begin
                    ackPend_next = 1'b1;
                    rdtStop = 1'b1;
                    unack_next = unackInc;
                end else begin
                    unack_next = unackInc;
                    rdtStart = !rdtRun;
                end
            end
        end
        if (concatOpp && rdtRun && !rdtStop) begin
            concat_next = 1'b1;
            rdtStop = 1'b1;
            unack_next = '0;
        end
        if (rdtExp) begin
            expPend_next = 1'b1;
        end
    end

    always_comb begin
        k_next = k_reg;
        k2_next = k2_reg;
        k3_next = k3_reg;
        rdt_next = rdt_reg;
        rdata_next = 32'h0000_0000;
        if (regWr && regAddr == lnka_pkg::ADDR_CFG) begin
            k_next = regWdata[lnka_pkg::K_LSB +: SW];
            k2_next = regWdata[lnka_pkg::K2_LSB +: SW];
            k3_next = regWdata[lnka_pkg::K3_LSB +: SW];
        end
        if (regWr && regAddr == lnka_pkg::ADDR_RDT) begin
            rdt_next = regWdata[lnka_pkg::RDT_W-1:0];
        end
        if (regRd) begin
            case (regAddr)
                lnka_pkg::ADDR_CFG: begin
                    rdata_next[lnka_pkg::K_LSB +: SW] = k_reg;
                    rdata_next[lnka_pkg::K2_LSB +: SW] = k2_reg;
                    rdata_next[lnka_pkg::K3_LSB +: SW] = k3_reg;
                end
                lnka_pkg::ADDR_RDT: rdata_next[lnka_pkg::RDT_W-1:0] = rdt_reg;
                lnka_pkg::ADDR_STAT: begin
                    rdata_next[lnka_pkg::ST_VS_LSB +: SW] = vs_reg;
                    rdata_next[lnka_pkg::ST_VR_LSB +: SW] = vr_reg;
                    rdata_next[lnka_pkg::ST_NR_LSB +: SW] = nrLast_reg;
                    rdata_next[lnka_pkg::ST_WFULL_BIT] = windowFull;
                    rdata_next[lnka_pkg::ST_RDTRUN_BIT] = rdtRun;
                    rdata_next[lnka_pkg::ST_BLOCK_BIT] = iBlock;
                end
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= lnka_pkg::LNKA_IDLE;
            vs_reg <= '0;
            vr_reg <= '0;
            nrLast_reg <= '0;
            unack_reg <= '0;
            pollRsp_reg <= 1'b0;
            k2Cmd_reg <= 1'b0;
            ackPend_reg <= 1'b0;
            expPend_reg <= 1'b0;
            iStart_reg <= 1'b0;
            ackStart_reg <= 1'b0;
            iNs_reg <= '0;
            iNr_reg <= '0;
            rxAcc_reg <= 1'b0;
            concat_reg <= 1'b0;
            k_reg <= lnka_pkg::K_RST;
            k2_reg <= lnka_pkg::K2_RST;
            k3_reg <= lnka_pkg::K3_RST;
            rdt_reg <= lnka_pkg::RDT_RST;
            rdata_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            vs_reg <= vs_next;
            vr_reg <= vr_next;
            nrLast_reg <= nrLast_next;
            unack_reg <= unack_next;
            pollRsp_reg <= pollRsp_next;
            k2Cmd_reg <= k2Cmd_next;
            ackPend_reg <= ackPend_next;
            expPend_reg <= expPend_next;
            iStart_reg <= iStart_next;
            ackStart_reg <= ackStart_next;
            iNs_reg <= iNs_next;
            iNr_reg <= iNr_next;
            rxAcc_reg <= rxAcc_next;
            concat_reg <= concat_next;
            k_reg <= k_next;
            k2_reg <= k2_next;
            k3_reg <= k3_next;
            rdt_reg <= rdt_next;
            rdata_reg <= rdata_next;
        end
    end

    assign regRdata = rdata_reg;
    assign iStart = iStart_reg;
    assign iNs = iNs_reg;
    assign iNr = iNr_reg;
    assign ackTimerStart = ackStart_reg;
    assign rxAccept = rxAcc_reg;
    assign concatS = concat_reg;
    // a poll answer goes before the k2 poll command
    assign sReq = pollRsp_reg | k2Cmd_reg | ackPend_reg | expPend_reg;
    assign sPf = pollRsp_reg | k2Cmd_reg;
    assign sCmd = !pollRsp_reg && k2Cmd_reg;
    assign sRnr = localBusy && !pollRsp_reg;
    assign sNr = vr_reg;
    assign sAppendOk = expPend_reg && !pollRsp_reg && !k2Cmd_reg;

    property p_ifields;
        @(posedge clk) disable iff (srst) iStart |-> (iNs == vs_reg) && (state_reg == lnka_pkg::LNKA_SEND);
    endproperty
    a_ifields: assert property (p_ifields) else $error("I PDU N(S) differs from V(S)");
    property p_vsinc;
        @(posedge clk) disable iff (srst) (state_reg == lnka_pkg::LNKA_SEND && iDone) |=> vs_reg == $past(vs_reg) + SW'(1);
    endproperty
    a_vsinc: assert property (p_vsinc) else $error("V(S) not advanced after send");
    property p_ackstart;
        @(posedge clk) disable iff (srst) iStart |-> ackTimerStart == !$past(ackTimerRunning);
    endproperty
    a_ackstart: assert property (p_ackstart) else $error("ack timer start wrong");
    property p_window;
        @(posedge clk) disable iff (srst) iStart |-> !$past(windowFull) && !$past(remoteBusy);
    endproperty
    a_window: assert property (p_window) else $error("I PDU sent with window full");
    property p_frmr;
        @(posedge clk) disable iff (srst) iStart |-> !$past(frmrCond);
    endproperty
    a_frmr: assert property (p_frmr) else $error("I PDU sent in FRMR");
    property p_recov;
        @(posedge clk) disable iff (srst) iStart |-> !$past(timerRecovery);
    endproperty
    a_recov: assert property (p_recov) else $error("I PDU sent in timer recovery");
    property p_accept;
        @(posedge clk) disable iff (srst) accept |=> vr_reg == $past(vr_reg) + SW'(1) && rxAccept;
    endproperty
    a_accept: assert property (p_accept) else $error("V(R) not advanced on accept");
    property p_k2;
        @(posedge clk) disable iff (srst)
            (state_reg == lnka_pkg::LNKA_SEND && iDone && modDiff(vs_reg + SW'(1), nrLast_reg) == k2_reg)
            |=> sReq && sPf;
    endproperty
    a_k2: assert property (p_k2) else $error("k2 poll command missing");
    property p_concat;
        @(posedge clk) disable iff (srst)
            (concatOpp && rdtRun && !accept && !(state_reg == lnka_pkg::LNKA_IDLE && canSend))
            |=> concatS && !rdtRun;
    endproperty
    a_concat: assert property (p_concat) else $error("concatenated ack missing");
    property p_rdtstart;
        @(posedge clk) disable iff (srst) (rdtStart && !rdtStop) |=> rdtRun;
    endproperty
    a_rdtstart: assert property (p_rdtstart) else $error("delay timer did not start");
endmodule
`default_nettype wire

// File: src/lnka_pkg.sv
// constants and types shared by the information-transfer acknowledgment block
package lnka_pkg;
    localparam int SEQ_W = 7;
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int RDT_W = 16;
    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_RDT = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam int K_LSB = 0;
    localparam int K2_LSB = 8;
    localparam int K3_LSB = 16;
    localparam int ST_VS_LSB = 0;
    localparam int ST_VR_LSB = 8;
    localparam int ST_NR_LSB = 16;
    localparam int ST_WFULL_BIT = 24;
    localparam int ST_RDTRUN_BIT = 25;
    localparam int ST_BLOCK_BIT = 26;
    localparam logic [SEQ_W-1:0] K_RST = 7'h07;
    localparam logic [SEQ_W-1:0] K2_RST = 7'h04;
    localparam logic [SEQ_W-1:0] K3_RST = 7'h02;
    localparam logic [RDT_W-1:0] RDT_RST = 16'h0064;
    typedef enum logic [0:0] {
        LNKA_IDLE = 1'b0,
        LNKA_SEND = 1'b1
    } lnka_state_t;
endpackage

// File: src/lnka_rdt_timer.sv
// response delay timer with its own microsecond tick divider
`timescale 1ns/1ns
`default_nettype none
module lnka_rdt_timer #(
    parameter int W = lnka_pkg::RDT_W,
    parameter int TICKS = lnka_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic stop,
    input wire logic [W-1:0] loadVal,
    output logic running,
    output logic expired
);
    logic [15:0] div_reg, div_next;
    logic [W-1:0] cnt_reg, cnt_next;
    logic run_reg, run_next;
    logic exp_reg, exp_next;
    logic tick;

    always_comb begin
        tick = (div_reg == 16'(TICKS - 1));
        div_next = tick ? 16'h0000 : div_reg + 16'h0001;
        cnt_next = cnt_reg;
        run_next = run_reg;
        exp_next = 1'b0;
        if (stop) begin
            run_next = 1'b0;
        end else if (start && !run_reg) begin
            run_next = 1'b1;
            cnt_next = (loadVal == '0) ? W'(1) : loadVal;
            div_next = 16'h0000;
        end else if (run_reg && tick) begin
            if (cnt_reg <= W'(1)) begin
                run_next = 1'b0;
                exp_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            div_reg <= 16'h0000;
            cnt_reg <= '0;
            run_reg <= 1'b0;
            exp_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            cnt_reg <= cnt_next;
            run_reg <= run_next;
            exp_reg <= exp_next;
        end
    end

    assign running = run_reg;
    assign expired = exp_reg;
endmodule
`default_nettype wire

// File: sim/lnka_far_station.sv
// far-side framer and local timer model: finishes I PDUs, takes S PDUs
`timescale 1ns/1ns
`default_nettype none
module lnka_far_station (
    input wire logic clk,
    input wire logic srst,
    input wire logic slow,
    input wire logic iStart,
    input wire logic sReq,
    input wire logic ackTimerStart,
    output logic iDone,
    output logic sAck,
    output logic ackTimerRunning
);
    int iCnt = 0;
    int sCnt = 0;
    int aCnt = 0;
    logic doneR = 1'b0;
    logic ackR = 1'b0;
    assign iDone = doneR;
    assign sAck = ackR;
    assign ackTimerRunning = aCnt != 0;
    always @(posedge clk) begin
        doneR <= 1'b0;
        ackR <= 1'b0;
        if (srst) begin
            iCnt <= 0;
            sCnt <= 0;
            aCnt <= 0;
        end else begin
            // transmission time of an I PDU, short or long
            if (iStart) iCnt <= slow ? 7 : 1;
            else if (iCnt > 0) iCnt <= iCnt - 1;
            if (iCnt == 1 && !iStart) doneR <= 1'b1;
            // the framer may stall before taking an S PDU
            if (sReq && sCnt == 0 && !ackR) sCnt <= slow ? 5 : 1;
            else if (sCnt > 0) sCnt <= sCnt - 1;
            if (sCnt == 1) ackR <= 1'b1;
            if (ackTimerStart) aCnt <= 40;
            else if (aCnt > 0) aCnt <= aCnt - 1;
        end
    end
endmodule
`default_nettype wire

// File: sim/link_info_transfer_ack_control_tb.sv
// self-checking bench for the information-transfer acknowledgment block
`timescale 1ns/1ns
`default_nettype none
module link_info_transfer_ack_control_tb;
    logic clk = 0, srst = 1, regWr = 0, regRd = 0, txPending = 0, localBusy = 0, remoteBusy = 0;
    logic frmrCond = 0, timerRecovery = 0, rxValid = 0, rxIsI = 0, rxIsS = 0, rxCmd = 0, rxPoll = 0;
    logic concatOpp = 0, slow = 0, iStart, iDone, ackTimerStart, ackTimerRunning, rxAccept, sReq, sAck;
    logic sCmd, sPf, sRnr, sAppendOk, concatS, sReqPrev = 0, rdPrev = 0, ackPrev = 0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [6:0] rxNs = 7'h00, rxNr = 7'h00, iNs, iNr, sNr, vr;
    byte expKind[$];
    logic [31:0] expVal[$];
    int n_mismatch = 0, checks = 0, cyc = 0, seed = 32'h636f;
    lnka_info_xfer lnka_info_xfer_inst (.clk, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .txPending, .iStart, .iNs, .iNr, .iDone, .ackTimerStart, .ackTimerRunning, .localBusy,
        .remoteBusy, .frmrCond, .timerRecovery, .rxValid, .rxIsI, .rxIsS, .rxCmd, .rxPoll, .rxNs,
        .rxNr, .rxAccept, .sReq, .sAck, .sCmd, .sPf, .sRnr, .sNr, .sAppendOk, .concatOpp, .concatS);
    lnka_far_station lnka_far_station_inst (.clk, .srst, .slow, .iStart, .sReq, .ackTimerStart,
        .iDone, .sAck, .ackTimerRunning);
    always #5 clk = ~clk;
    task automatic stop_test();
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 15000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic bad(input string m);
        n_mismatch++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic ex(input byte k, input logic [31:0] v);
        expKind.push_back(k);
        expVal.push_back(v);
    endtask
    function automatic logic [31:0] sv(input logic ap, cm, pf, input logic [6:0] nr);
        return {21'h0, ap, cm, pf, 1'b0, nr};
    endfunction
    function automatic logic [31:0] st(input logic [6:0] vs, v, nr, input logic [2:0] f);
        return {5'h0, f, 1'b0, nr, 1'b0, v, 1'b0, vs};
    endfunction
    task automatic chk(input byte k, input logic [31:0] v);
        checks++;
        if (expKind.size() == 0) bad("unexpected output event");
        else begin
            if (expKind[0] != k || expVal[0] !== v) bad($sformatf("got %s %h want %s %h", k, v, expKind[0], expVal[0]));
            expKind.pop_front();
            expVal.pop_front();
        end
    endtask
    always @(negedge clk) begin
        if (!srst) begin
            if (rxAccept !== 1'b0) chk("A", 32'h0);
            if (iStart !== 1'b0) chk("I", {18'h0, iNs, iNr});
            if (sReq === 1'b1 && sReqPrev !== 1'b1) chk("S", {21'h0, sAppendOk, sCmd, sPf, sRnr, sNr});
            if (concatS !== 1'b0) chk("C", {25'h0, sNr});
            if (rdPrev) chk("R", regRdata);
            if (iStart !== 1'b0 || ackTimerStart !== 1'b0) begin
                checks++;
                if (ackTimerStart !== (iStart & ~ackPrev)) bad("ack timer start wrong");
            end
        end
        sReqPrev = sReq;
        rdPrev = regRd;
        ackPrev = ackTimerRunning;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        ex("R", e);
        @(posedge clk);
        regRd <= 1'b0;
    endtask
    task automatic rx(input logic i, cm, pl, input logic [6:0] ns, nr);
        @(posedge clk);
        rxValid <= 1'b1;
        rxIsI <= i;
        rxIsS <= !i;
        rxCmd <= cm;
        rxPoll <= pl;
        rxNs <= ns;
        rxNr <= nr;
        @(posedge clk);
        rxValid <= 1'b0;
    endtask
    task automatic quiet(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic drain(input int lim);
        int t;
        t = 0;
        while ((expKind.size() != 0 || sReq !== 1'b0) && t < lim) begin
            @(posedge clk);
            t++;
        end
        if (expKind.size() != 0 || sReq !== 1'b0) bad("expected event missing");
        quiet(2);
    endtask
    task automatic send1(input logic [31:0] e);
        int t;
        t = 0;
        ex("I", e);
        txPending <= 1'b1;
        while (expKind.size() != 0 && t < 50) begin
            @(posedge clk);
            t++;
        end
        txPending <= 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd(lnka_pkg::ADDR_CFG, {9'h0, lnka_pkg::K3_RST, 1'b0, lnka_pkg::K2_RST, 1'b0, lnka_pkg::K_RST});
        rd(lnka_pkg::ADDR_RDT, {16'h0, lnka_pkg::RDT_RST});
        wr(lnka_pkg::ADDR_STAT, 32'hFFFFFFFF);
        rd(lnka_pkg::ADDR_STAT, 32'h0);
        rd(4'hC, 32'h0);
        wr(lnka_pkg::ADDR_CFG, 32'h00030203);
        wr(lnka_pkg::ADDR_RDT, 32'h00000002);
        rd(lnka_pkg::ADDR_CFG, 32'h00030203);
        drain(10);
        slow <= 1'b1;
        ex("I", 32'h0);
        ex("I", 32'h80);
        ex("S", sv(0, 1, 1, 7'h00));
        ex("I", 32'h100);
        txPending <= 1'b1;
        drain(80);
        quiet(20);
        rd(lnka_pkg::ADDR_STAT, st(7'h03, 7'h00, 7'h00, 3'b101));
        drain(10);
        for (int i = 0; i < 3; i++) begin
            {frmrCond, timerRecovery, remoteBusy} <= 3'b100 >> i;
            if (i == 0) rx(1'b0, 1'b0, 1'b0, 7'h00, 7'h03);
            quiet(15);
        end
        {frmrCond, timerRecovery, remoteBusy, localBusy} <= 4'h1;
        send1(32'h180);
        drain(50);
        localBusy <= 1'b0;
        slow <= 1'b0;
        rx(1'b1, 1'b1, 1'b1, 7'h00, 7'h04);
        ex("A", 32'h0);
        ex("S", sv(0, 0, 1, 7'h01));
        drain(50);
        rx(1'b1, 1'b0, 1'b0, 7'h05, 7'h04);
        localBusy <= 1'b1;
        rx(1'b1, 1'b0, 1'b0, 7'h01, 7'h04);
        localBusy <= 1'b0;
        quiet(10);
        for (int j = 1; j < 4; j++) begin
            rx(1'b1, 1'b0, 1'b0, 7'(j), 7'h04);
            ex("A", 32'h0);
            if (j == 3) ex("S", sv(0, 0, 0, 7'h04));
            drain(20);
        end
        quiet(300);
        rx(1'b1, 1'b0, 1'b0, 7'h04, 7'h04);
        ex("A", 32'h0);
        localBusy <= 1'b1;
        quiet(60);
        rd(lnka_pkg::ADDR_STAT, st(7'h04, 7'h05, 7'h04, 3'b010));
        ex("S", sv(1, 0, 0, 7'h05) | 32'h80);
        drain(400);
        localBusy <= 1'b0;
        rx(1'b1, 1'b0, 1'b0, 7'h05, 7'h04);
        ex("A", 32'h0);
        quiet(5);
        concatOpp <= 1'b1;
        ex("C", 32'h06);
        @(posedge clk);
        concatOpp <= 1'b0;
        quiet(300);
        rx(1'b1, 1'b0, 1'b0, 7'h06, 7'h04);
        ex("A", 32'h0);
        quiet(3);
        send1(32'h207);
        quiet(300);
        rx(1'b0, 1'b1, 1'b1, 7'h00, 7'h05);
        ex("S", sv(0, 0, 1, 7'h07));
        drain(50);
        vr = 7'h07;
        repeat (260) begin
            slow <= 1'($random(seed));
            if ($random(seed) % 2 == 0) begin
                rx(1'b1, 1'b1, 1'b1, vr, 7'h05);
                vr = vr + 7'h01;
                ex("A", 32'h0);
                ex("S", sv(0, 0, 1, vr));
            end else begin
                rx(1'b1, 1'b1, 1'b0, vr + 7'h01 + 7'($random(seed) & 63), 7'h05);
            end
            drain(60);
        end
        rd(lnka_pkg::ADDR_STAT, st(7'h05, vr, 7'h05, 3'b000));
        drain(10);
        stop_test();
    end
endmodule
`default_nettype wire
